// *** core/hfar_pkg.sv ***
package hfar_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] ADDR_ALERT_ENABLE  = 8'h01;
  localparam logic [7:0] ADDR_FAULT_HISTORY = 8'h03;
  localparam logic [7:0] ADDR_SHUNT_DROP    = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT_RAIL   = 8'h05;
  localparam logic [7:0] ADDR_AUX_INPUT     = 8'h06;

  // fault-history field positions
  localparam int FLT_SWITCH_SHORT = 5;
  localparam int FLT_ENABLE_CHG   = 4;
  localparam int FLT_POWER_BAD    = 3;
  localparam int FLT_OVERCURRENT  = 2;
  localparam int FLT_UNDERVOLT    = 1;
  localparam int FLT_OVERVOLT     = 0;

  // implemented bits: 7 and 6 are reserved and read zero
  localparam logic [7:0] FAULT_MASK    = 8'h3F;
  localparam logic [7:0] FAULT_RESET   = 8'h00;
  localparam logic [7:0] ALERT_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // shunt drop above 1 mV with the switch off flags a short.
  // step 151 uV, so 1 mV is 6.6 steps: any code of 7 or more exceeds it.
  localparam int         SHUNT_STEP_NV    = 151_000;
  localparam int         SHORT_LIMIT_NV   = 1_000_000;
  localparam logic [7:0] SHORT_LIMIT_CODE = 8'(SHORT_LIMIT_NV / SHUNT_STEP_NV);

  // converter channel selects
  typedef enum logic [1:0] {
    HFAR_CH_SHUNT,
    HFAR_CH_RAIL,
    HFAR_CH_AUX
  } hfar_chan_type;

endpackage : hfar_pkg

// *** core/hfar_sample_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// one converter result handed from the sampler to the register slice
interface hfar_sample_if;
  import hfar_pkg::*;
  logic          valid;    // one-cycle strobe
  hfar_chan_type chan;     // which result register
  logic [7:0]    code;     // unsigned result
  modport source (output valid, output chan, output code);
  modport sink   (input valid, input chan, input code);
endinterface : hfar_sample_if
`default_nettype wire

// *** core/hfar_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser: a change counts once stages two and three agree
module hfar_sync3 import hfar_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] s1, s2, s3;  // stage one feeds only stage two
  logic [W-1:0] next_out;

  // hold last agreed value while stages disagree
  always_comb begin
    next_out = sync_out;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_out[i] = s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      sync_out <= '0;
    end else begin
      s1       <= async_in;
      s2       <= s1;
      s3       <= s2;
      sync_out <= next_out;
    end
  end
endmodule : hfar_sync3
`default_nettype wire

// *** core/hfar_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none
// converter front end: captures a finished conversion whole and forwards it
module hfar_sampler import hfar_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        conv_done,   // same-domain strobe from the converter
  input  wire logic [1:0]  conv_chan,   // channel of that conversion
  input  wire logic [7:0]  conv_code,   // full result word
  hfar_sample_if.source    smp
);
  logic          next_valid;
  hfar_chan_type next_chan;
  logic [7:0]    next_code;

  // only known channels make it through; a stray select is dropped
  always_comb begin
    next_valid = conv_done && (conv_chan <= 2'(HFAR_CH_AUX));
    next_chan  = hfar_chan_type'(conv_chan);
    next_code  = conv_code;
  end

  // the whole word moves in one edge, so a read never sees half a result
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      smp.valid <= 1'b0;
      smp.chan  <= HFAR_CH_SHUNT;
      smp.code  <= RESULT_RESET;
    end else begin
      smp.valid <= next_valid;
      smp.chan  <= next_chan;
      smp.code  <= next_code;
    end
  end
endmodule : hfar_sampler
`default_nettype wire

// *** core/hfar_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module hfar_regs import hfar_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // fault conditions from comparators and control
  input  wire logic       enable_pin,
  input  wire logic       power_good_feedback,
  input  wire logic       undervoltage_input,
  input  wire logic       high_supply_trip_input,
  input  wire logic       overcurrent_event,
  input  wire logic       switch_on_cmd,
  // converter results
  input  wire logic       conv_done,
  input  wire logic [1:0] conv_chan,
  input  wire logic [7:0] conv_code,
  // combined alert request
  output var  logic       alert
);

  // pins cross into mclk through three flops and an output hold flop
  logic [4:0] pins_raw;   // asynchronous comparator and pin levels
  logic [4:0] pins_sync;  // agreed levels
  logic       en_s;       // enable pin
  logic       pg_s;       // power-good feedback
  logic       uv_s;       // undervoltage comparator
  logic       ov_s;       // overvoltage comparator
  logic       oc_s;       // overcurrent fault level

  assign pins_raw = {enable_pin, power_good_feedback, undervoltage_input,
                     high_supply_trip_input, overcurrent_event};
  assign {en_s, pg_s, uv_s, ov_s, oc_s} = pins_sync;

  hfar_sync3 #(.W(5)) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  // converter results arrive as whole words
  hfar_sample_if smp ();

  hfar_sampler u_sampler (
    .mclk      (mclk),
    .nrst      (nrst),
    .conv_done (conv_done),
    .conv_chan (conv_chan),
    .conv_code (conv_code),
    .smp       (smp.source)
  );

  // register state
  logic [7:0] fault_history;       // sticky fault flags
  logic [7:0] alert_enable;        // per-fault alert gate
  logic [7:0] shunt_drop_result;   // latest shunt conversion
  logic [7:0] output_rail_result;  // latest rail conversion
  logic [7:0] aux_input_result;    // latest aux conversion
  logic       en_prev;             // last seen enable level
  logic       en_primed;           // first level after reset captured
  logic       sw_off_q;            // switch-off command, registered

  logic [7:0] next_fault_history;
  logic [7:0] next_alert_enable;
  logic [7:0] next_shunt_drop_result;
  logic [7:0] next_output_rail_result;
  logic [7:0] next_aux_input_result;
  logic [7:0] next_reg_rdata;
  logic       next_alert;
  logic       next_en_prev;
  logic       next_en_primed;
  logic       next_sw_off_q;
  logic [7:0] fault_set;           // conditions seen this cycle

  // address decode, used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // fault detection
  always_comb begin
    fault_set = 8'h00;
    // short suspected only once a fresh shunt code shows it with switch off
    if (smp.valid && smp.chan == HFAR_CH_SHUNT && sw_off_q &&
        smp.code > SHORT_LIMIT_CODE) begin
      fault_set[FLT_SWITCH_SHORT] = 1'b1;
    end
    // edge needs a primed reference, else reset looks like a change
    if (en_primed && en_s != en_prev) begin
      fault_set[FLT_ENABLE_CHG] = 1'b1;
    end
    if (!pg_s) begin
      fault_set[FLT_POWER_BAD] = 1'b1;
    end
    if (oc_s) begin
      fault_set[FLT_OVERCURRENT] = 1'b1;
    end
    if (!uv_s) begin
      fault_set[FLT_UNDERVOLT] = 1'b1;
    end
    if (ov_s) begin
      fault_set[FLT_OVERVOLT] = 1'b1;
    end
  end

  // register writes, result capture and sticky flags
  always_comb begin
    next_fault_history      = fault_history;
    next_alert_enable       = alert_enable;
    next_shunt_drop_result  = shunt_drop_result;
    next_output_rail_result = output_rail_result;
    next_aux_input_result   = aux_input_result;
    next_en_prev            = en_s;
    next_en_primed          = 1'b1;
    next_sw_off_q           = !switch_on_cmd;

    // host write: zero clears a flag, one may set it (fault injection)
    if (reg_wr) begin
      if (hit(reg_addr, ADDR_FAULT_HISTORY)) begin
        next_fault_history = reg_wdata & FAULT_MASK;
      end else if (hit(reg_addr, ADDR_ALERT_ENABLE)) begin
        next_alert_enable = reg_wdata & FAULT_MASK;
      end else if (hit(reg_addr, ADDR_SHUNT_DROP)) begin
        next_shunt_drop_result = reg_wdata;
      end else if (hit(reg_addr, ADDR_OUTPUT_RAIL)) begin
        next_output_rail_result = reg_wdata;
      end else if (hit(reg_addr, ADDR_AUX_INPUT)) begin
        next_aux_input_result = reg_wdata;
      end
    end

    // a fresh conversion wins over a host write of the same register
    if (smp.valid) begin
      case (smp.chan)
        HFAR_CH_SHUNT: begin
          next_shunt_drop_result = smp.code;
        end
        HFAR_CH_RAIL: begin
          next_output_rail_result = smp.code;
        end
        HFAR_CH_AUX: begin
          next_aux_input_result = smp.code;
        end
        default: begin
          next_aux_input_result = aux_input_result;
        end
      endcase
    end

    // set beats clear: a fault in the clearing cycle stays recorded
    next_fault_history = (next_fault_history | fault_set) & FAULT_MASK;
  end

  // read mux and alert
  always_comb begin
    next_reg_rdata = UNMAPPED_READ;
    if (reg_rd) begin
      if (hit(reg_addr, ADDR_FAULT_HISTORY)) begin
        next_reg_rdata = fault_history & FAULT_MASK;
      end else if (hit(reg_addr, ADDR_ALERT_ENABLE)) begin
        next_reg_rdata = alert_enable;
      end else if (hit(reg_addr, ADDR_SHUNT_DROP)) begin
        next_reg_rdata = shunt_drop_result;
      end else if (hit(reg_addr, ADDR_OUTPUT_RAIL)) begin
        next_reg_rdata = output_rail_result;
      end else if (hit(reg_addr, ADDR_AUX_INPUT)) begin
        next_reg_rdata = aux_input_result;
      end
    end
    // alert only for enabled fault types, from the updated history
    next_alert = |(next_fault_history & next_alert_enable);
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fault_history      <= FAULT_RESET;
      alert_enable       <= ALERT_RESET;
      shunt_drop_result  <= RESULT_RESET;
      output_rail_result <= RESULT_RESET;
      aux_input_result   <= RESULT_RESET;
      en_prev            <= 1'b0;
      en_primed          <= 1'b0;
      sw_off_q           <= 1'b1;
      reg_rdata          <= UNMAPPED_READ;
      alert              <= 1'b0;
    end else begin
      fault_history      <= next_fault_history;
      alert_enable       <= next_alert_enable;
      shunt_drop_result  <= next_shunt_drop_result;
      output_rail_result <= next_output_rail_result;
      aux_input_result   <= next_aux_input_result;
      en_prev            <= next_en_prev;
      en_primed          <= next_en_primed;
      sw_off_q           <= next_sw_off_q;
      reg_rdata          <= next_reg_rdata;
      alert              <= next_alert;
    end
  end

endmodule : hfar_regs
`default_nettype wire

// *** verification/hfar_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the fault and result slice
module hfar_regs_monitor import hfar_pkg::*; (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       enable_pin,
  input wire logic       power_good_feedback,
  input wire logic       undervoltage_input,
  input wire logic       high_supply_trip_input,
  input wire logic       overcurrent_event,
  input wire logic       switch_on_cmd,
  input wire logic       conv_done,
  input wire logic [1:0] conv_chan,
  input wire logic [7:0] conv_code,
  input wire logic       alert
);
  logic [5:0] en_sh; // shadow of the alert enables as last written
  // shadow kept here since the enables are not visible at the ports
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      en_sh <= 6'h00;
    end else if (reg_wr && reg_addr == ADDR_ALERT_ENABLE) begin
      en_sh <= reg_wdata[5:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_result;
    logic [7:0] v, a;
    (conv_done && conv_chan != 2'h3, v = conv_code, a = ADDR_SHUNT_DROP + 8'(conv_chan))
      ##2 (reg_rd && reg_addr == a) |=> reg_rdata == v;
  endproperty
  a_result: assert property (p_result) else $error("result not read back whole");
  property p_mask; reg_wr && reg_addr == ADDR_ALERT_ENABLE && reg_wdata[5:0] == 6'h00
    ##1 !reg_wr |=> !alert; endproperty
  a_mask: assert property (p_mask) else $error("alert with all enables off");
  property p_sticky; alert && !reg_wr |=> alert; endproperty
  a_sticky: assert property (p_sticky) else $error("alert dropped without a write");
  property p_short; conv_done && conv_chan == 2'h0 && conv_code > SHORT_LIMIT_CODE
    && !switch_on_cmd && en_sh[5] ##0 !reg_wr [*3] |=> alert; endproperty
  a_short: assert property (p_short) else $error("switch short not flagged");
  property p_en_chg; en_sh[4] && $changed(enable_pin) ##0 !reg_wr [*6] |=> alert; endproperty
  a_en_chg: assert property (p_en_chg) else $error("enable change not flagged");
  property p_pbad; !power_good_feedback [*6] ##0 en_sh[3] |-> alert; endproperty
  a_pbad: assert property (p_pbad) else $error("power bad not flagged");
  property p_ov; high_supply_trip_input [*6] ##0 en_sh[0] |-> alert; endproperty
  a_ov: assert property (p_ov) else $error("overvoltage not flagged");
endmodule // hfar_regs_monitor
bind hfar_regs hfar_regs_monitor u_mon (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .enable_pin, .power_good_feedback, .undervoltage_input, .high_supply_trip_input,
  .overcurrent_event, .switch_on_cmd, .conv_done, .conv_chan, .conv_code, .alert);
`default_nettype wire

// *** verification/hfar_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: one result per request, after lat idle cycles
module hfar_conv_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [1:0] ch,
  input  wire logic [7:0] code,
  input  wire logic [3:0] lat,
  output var  logic       conv_done,
  output var  logic [1:0] conv_chan,
  output var  logic [7:0] conv_code
);
  logic       busy = 1'b0; // a request is pending
  logic [3:0] cnt;         // idle cycles left
  logic [1:0] hch;         // held channel
  logic [7:0] hcode;       // held result
  initial {conv_done, conv_chan, conv_code} = 11'h000;
  // between strobes the lines toggle, so a stale word is never mistaken for valid
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    conv_chan <= ~conv_chan;
    conv_code <= ~conv_code;
    if (go) begin
      {busy, cnt, hch, hcode} <= {1'b1, lat, ch, code};
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      {conv_done, conv_chan, conv_code} <= {1'b1, hch, hcode};
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // hfar_conv_model
`default_nettype wire

// *** verification/hotswap_fault_adc_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module hotswap_fault_adc_regs_bench import hfar_pkg::*;;
  logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, alert, conv_done;
  logic enable_pin = 1'b0, power_good_feedback = 1'b1, undervoltage_input = 1'b1;
  logic high_supply_trip_input = 1'b0, overcurrent_event = 1'b0, switch_on_cmd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, m_code = 8'h00, reg_rdata, conv_code;
  logic [1:0] m_chan = 2'h0, conv_chan;
  logic [3:0] m_lat = 4'h0;
  logic [7:0] sc [3] = '{8'h06, 8'h07, 8'hC8}; // codes either side of the short limit
  int pos [5] = '{FLT_OVERVOLT, FLT_UNDERVOLT, FLT_POWER_BAD, FLT_OVERCURRENT, FLT_ENABLE_CHG};
  int fail_count = 0, comparisons = 0, i;
  hfar_regs u_dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .enable_pin, .power_good_feedback, .undervoltage_input, .high_supply_trip_input,
    .overcurrent_event, .switch_on_cmd, .conv_done, .conv_chan, .conv_code, .alert);
  hfar_conv_model u_model (.mclk, .go, .ch(m_chan), .code(m_code), .lat(m_lat),
    .conv_done, .conv_chan, .conv_code);
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // raise or drop one fault condition, in its own polarity
  task automatic fault(input int n, input logic on);
    case (n)
      0: high_supply_trip_input <= on;
      1: undervoltage_input <= !on;
      2: power_good_feedback <= !on;
      3: overcurrent_event <= on;
      default: enable_pin <= on;
    endcase
  endtask
  // returns at the edge where the strobe is seen; a lost strobe ends the run
  task automatic conv(input logic [1:0] c, input logic [7:0] d, input logic [3:0] l);
    @(posedge mclk);
    {go, m_chan, m_code, m_lat} <= {1'b1, c, d, l};
    @(posedge mclk);
    go <= 1'b0;
    for (int k = 0; k < 40 && !conv_done; k++) @(posedge mclk);
    if (!conv_done) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(ADDR_FAULT_HISTORY, 8'h00); // power-good and undervoltage syncs start at fault level, so flush
    rd(ADDR_FAULT_HISTORY, FAULT_RESET);
    rd(ADDR_ALERT_ENABLE, ALERT_RESET);
    for (i = 0; i < 3; i++) rd(ADDR_SHUNT_DROP + 8'(i), RESULT_RESET);
    rd(8'h07, UNMAPPED_READ);
    wr(ADDR_FAULT_HISTORY, 8'hFF);
    rd(ADDR_FAULT_HISTORY, FAULT_MASK);
    wr(ADDR_OUTPUT_RAIL, 8'hA5);
    rd(ADDR_OUTPUT_RAIL, 8'hA5);
    wr(ADDR_FAULT_HISTORY, 8'h00);
    $display("test access done");
    wr(ADDR_ALERT_ENABLE, 8'h3F);
    for (i = 0; i < 5; i++) begin
      fault(i, 1'b1);
      repeat (8) @(posedge mclk);
      if (i != 4) wr(ADDR_FAULT_HISTORY, 8'h00); // set wins while the condition stands
      rd(ADDR_FAULT_HISTORY, 8'h01 << pos[i]);
      fault(i, 1'b0);
      repeat (8) @(posedge mclk);
      rd(ADDR_FAULT_HISTORY, 8'h01 << pos[i]);
      chk({7'h00, alert}, 8'h01);
      wr(ADDR_FAULT_HISTORY, 8'h00);
      rd(ADDR_FAULT_HISTORY, 8'h00);
    end
    fault(0, 1'b1);
    repeat (8) @(posedge mclk);
    wr(ADDR_ALERT_ENABLE, 8'h00);
    @(posedge mclk);
    #1 chk({7'h00, alert}, 8'h00);
    wr(ADDR_ALERT_ENABLE, 8'h01);
    #1 chk({7'h00, alert}, 8'h01);
    fault(0, 1'b0);
    $display("test faults done");
    for (i = 0; i < 3; i++) begin
      conv(i[1:0], 8'h5A + 8'(i), 4'(3 * i));
      rd(ADDR_SHUNT_DROP + 8'(i), 8'h5A + 8'(i));
    end
    conv(2'h3, 8'h11, 4'h2);
    repeat (3) @(posedge mclk);
    for (i = 0; i < 3; i++) rd(ADDR_SHUNT_DROP + 8'(i), 8'h5A + 8'(i));
    wr(ADDR_ALERT_ENABLE, 8'h20);
    for (i = 0; i < 3; i++) begin
      switch_on_cmd <= (i == 2);
      wr(ADDR_FAULT_HISTORY, 8'h00);
      conv(2'h0, sc[i], 4'h0);
      repeat (3) @(posedge mclk);
      rd(ADDR_FAULT_HISTORY, (i == 1) ? 8'h01 << FLT_SWITCH_SHORT : 8'h00);
    end
    $display("test converter done");
    tally_and_finish();
  end
endmodule // hotswap_fault_adc_regs_bench
`default_nettype wire
